// File: breakpoint_mask_rw_qualifier.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "bkpt_consts.svh"

// How it works
// - full paged compare: page plus address 13:0
// - full unpaged compare: all sixteen address bits
// - first mask: full, 256-byte or 16K range
// - second mask same meanings in dual mode
// - first mask 1:0 compares all lines
// - second mask 1:0 compares all lines
// - 1:1 fires only on matching paged access
// - full mode second mask picks data bytes
// - debug mode forces first mask to zero
// - debug mode second mask only qualifies data
// - A direction used only when enabled
// - A direction value: 0 write, 1 read
// - B direction used only when enabled
// - B direction value: 0 write, 1 read
// - full mode ignores B direction bits
// - full mode: A address, B data
// - B bits compare data bits in full
module breakpoint_mask_rw_qualifier (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output bkpt_pkg::axi_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output bkpt_pkg::axi_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic bus_valid,
    input wire logic [15:0] cpu_addr,
    input wire logic [5:0] program_page_select,
    input wire logic program_page_access,
    input wire logic [15:0] cpu_data,
    input wire logic cpu_read,
    output logic match_a,
    output logic match_b,
    output logic irq
);
    import bkpt_pkg::*;

    // =====================================================
    // overview
    // the cpu side is sampled once per clock; a hit on
    // cycle n shows on match_a or match_b at cycle n+1
    // and lands in the sticky status at the same time.
    // irq is set from the next status in the same cycle, so a
    // matching cycle reaches the interrupt line in one
    // clock. the register bus never stalls the compare:
    // a control write simply changes the rule for the
    // next sampled bus cycle.
    // there is no tagging here; every match is treated
    // as a forced break, and the direction bits are
    // meaningful to this logic, except B's in full mode.

    // =====================================================
    // registers
    logic [7:0] ctrl_r; // mask and direction control
    logic [21:0] cmp_a_r; // extended, high, low of comparator A
    logic [21:0] cmp_b_r; // extended, high, low of comparator B
    logic [1:0] mode_r; // breakpoint_mode, full select
    logic [1:0] irq_status_r; // sticky match events
    logic [1:0] irq_mask_r; // 1 enables the event
    logic match_a_r;
    logic match_b_r;
    logic irq_r;

    // =====================================================
    // mode decode
    // mode bit 0 high selects breakpoint operation,
    // low selects the trace/debug use of the comparators.
    // mode bit 1 turns comparator B into a data compare.
    // the masks are re-qualified here rather than at the
    // register so a later mode change never needs a
    // rewrite of the control byte by software.
    wire breakpoint_mode = mode_r[`F_MODE_BKPT]; // 0 means debug_trace_mode
    wire full_mode = mode_r[`F_MODE_FULL];
    wire [5:0] cmp_a_extended_byte = cmp_a_r[21:16];
    wire [7:0] cmp_a_high_byte = cmp_a_r[15:8];
    wire [7:0] cmp_a_low_byte = cmp_a_r[7:0];
    wire [5:0] cmp_b_extended_byte = cmp_b_r[21:16];
    wire [7:0] cmp_b_high_byte = cmp_b_r[15:8];
    wire [7:0] cmp_b_low_byte = cmp_b_r[7:0];

    // debug mode: first mask has no meaning, held at zero
    wire first_addr_high_mask = breakpoint_mode & ctrl_r[`F_A_MASK_H];
    wire first_addr_low_mask = breakpoint_mode & ctrl_r[`F_A_MASK_L];
    wire second_addr_high_mask = ctrl_r[`F_B_MASK_H];
    wire second_addr_low_mask = ctrl_r[`F_B_MASK_L];
    // second mask in debug mode counts only for the data compare
    wire b_mask_h_addr = breakpoint_mode & second_addr_high_mask;
    wire b_mask_l_addr = breakpoint_mode & second_addr_low_mask;
    wire cmp_a_dir_enable = ctrl_r[`F_A_DIR_EN];
    wire cmp_a_dir_value = ctrl_r[`F_A_DIR_VAL];
    wire cmp_b_dir_enable = ctrl_r[`F_B_DIR_EN];
    wire cmp_b_dir_value = ctrl_r[`F_B_DIR_VAL];

    // =====================================================
    // address field matches, shared shape for A and B
    // both comparators use the same slicing: six page
    // bits, then either six or eight high address bits,
    // then the low byte. on a program page the two top
    // address lines are replaced by the page, which gives
    // the twenty-bit compare; elsewhere the full sixteen
    // bits are used and the page value plays no part.
    // limitation: several physical addresses alias to one
    // logical address when the page is not compared.
    // paged: page vs extended byte, high byte bits 5:0 vs address 13:8
    wire a_ext_eq = program_page_select == cmp_a_extended_byte;
    wire b_ext_eq = program_page_select == cmp_b_extended_byte;
    wire a_hi_eq = program_page_access ? (cpu_addr[13:8] == cmp_a_high_byte[5:0])
                                       : (cpu_addr[15:8] == cmp_a_high_byte);
    wire b_hi_eq = program_page_access ? (cpu_addr[13:8] == cmp_b_high_byte[5:0])
                                       : (cpu_addr[15:8] == cmp_b_high_byte);
    wire a_lo_eq = cpu_addr[7:0] == cmp_a_low_byte;
    wire b_lo_eq = cpu_addr[7:0] == cmp_b_low_byte;

    // mask decode: low bit clear means full compare whatever the high bit
    wire a_use_hi = ~(first_addr_high_mask & first_addr_low_mask);
    wire a_use_lo = ~first_addr_low_mask;
    wire b_use_hi = ~(b_mask_h_addr & b_mask_l_addr);
    wire b_use_lo = ~b_mask_l_addr;
    // 16K range outside a program page can never fire
    wire a_range_only = ~a_use_hi;
    wire b_range_only = ~b_use_hi;
    // extended byte only counts on a program page access
    wire a_ext_ok = program_page_access ? a_ext_eq : ~a_range_only;
    wire b_ext_ok = program_page_access ? b_ext_eq : ~b_range_only;

    wire a_addr_hit = a_ext_ok & (~a_use_hi | a_hi_eq) & (~a_use_lo | a_lo_eq);
    wire b_addr_hit = b_ext_ok & (~b_use_hi | b_hi_eq) & (~b_use_lo | b_lo_eq);

    // =====================================================
    // data compare for full mode, extended byte never used
    // the second mask bits act as byte disables here:
    // high bit masks the high data byte, low bit the low.
    // with both set comparator B matches any cycle that
    // passes the bus_valid gate, which is intended.
    wire d_use_hi = ~second_addr_high_mask;
    wire d_use_lo = ~second_addr_low_mask;
    wire d_hi_eq = cpu_data[15:8] == cmp_b_high_byte;
    wire d_lo_eq = cpu_data[7:0] == cmp_b_low_byte;
    wire b_data_hit = (~d_use_hi | d_hi_eq) & (~d_use_lo | d_lo_eq);

    // =====================================================
    // direction qualification; value 1 matches read cycles
    // an enable bit left clear makes the value bit a
    // don't-care. in full mode B follows A's direction
    // only through the shared bus cycle, never its own.
    wire a_dir_ok = ~cmp_a_dir_enable | (cmp_a_dir_value == cpu_read);
    wire b_dir_ok = full_mode | ~cmp_b_dir_enable | (cmp_b_dir_value == cpu_read);

    wire hit_a = bus_valid & a_addr_hit & a_dir_ok;
    wire hit_b = bus_valid & b_dir_ok & (full_mode ? b_data_hit : b_addr_hit);

    // =====================================================
    // axi write channel: address and data accepted in either order
    // each channel is latched on its own handshake and
    // held until the partner arrives; the write is done
    // in the cycle where both are present, so a master
    // that offers both together sees the response one
    // clock after the handshake. a pending response
    // blocks both channels, keeping one write in flight.
    wr_state_t wr_state_r;
    logic aw_got_r;
    logic w_got_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    axi_resp_t bresp_r;

    wire aw_fire = s_axi_awvalid & ~aw_got_r & (wr_state_r != WS_RESP);
    wire w_fire = s_axi_wvalid & ~w_got_r & (wr_state_r != WS_RESP);
    wire have_aw = aw_got_r | aw_fire;
    wire have_w = w_got_r | w_fire;
    wire [11:0] wa = aw_fire ? s_axi_awaddr : awaddr_r;
    wire [31:0] wd = w_fire ? s_axi_wdata : wdata_r;
    wire [3:0] ws = w_fire ? s_axi_wstrb : wstrb_r;
    wire do_write = have_aw & have_w & (wr_state_r != WS_RESP);
    wire wr_ctrl = wa == 12'(`ADDR_MASK_RW_CTRL);
    wire wr_cmp_a = wa == `ADDR_CMP_A;
    wire wr_cmp_b = wa == `ADDR_CMP_B;
    wire wr_mode = wa == `ADDR_MODE;
    wire wr_mask = wa == `ADDR_IRQ_MASK;
    wire wr_known = wr_ctrl | wr_cmp_a | wr_cmp_b | wr_mode | wr_mask
                  | (wa == `ADDR_IRQ_STATUS) | (wa == `ADDR_MATCH_STATE);

    // byte-lane merge for the comparator words
    wire [21:0] cmp_wmask = {{6{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
    wire [21:0] cmp_a_nxt = (cmp_a_r & ~cmp_wmask) | (wd[21:0] & cmp_wmask);
    wire [21:0] cmp_b_nxt = (cmp_b_r & ~cmp_wmask) | (wd[21:0] & cmp_wmask);

    // write handshake state
    // idle: nothing held. collect: one channel held,
    // waiting for the other. resp: bvalid raised and
    // held until bready; the payload flops keep their
    // last values, which is harmless since do_write is
    // gated off in that state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r <= WS_IDLE;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (aw_fire) awaddr_r <= s_axi_awaddr;
            if (w_fire) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            case (wr_state_r)
                WS_IDLE, WS_COLLECT: begin
                    if (do_write) begin
                        wr_state_r <= WS_RESP;
                        aw_got_r <= 1'b0;
                        w_got_r <= 1'b0;
                        bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
                    end else begin
                        aw_got_r <= have_aw;
                        w_got_r <= have_w;
                        wr_state_r <= (have_aw | have_w) ? WS_COLLECT : WS_IDLE;
                    end
                end
                WS_RESP: begin
                    if (s_axi_bready) wr_state_r <= WS_IDLE;
                end
                default: wr_state_r <= WS_IDLE;
            endcase
        end
    end

    // =====================================================
    // axi read channel, one cycle to data
    // the address is decoded combinationally from the
    // bus and the data registered at the handshake, so
    // read data never changes while rvalid stands.
    // arready drops while data waits: one read at a time.
    logic rvalid_r;
    logic [31:0] rdata_r;
    axi_resp_t rresp_r;
    wire ar_fire = s_axi_arvalid & ~rvalid_r;
    wire rd_status = s_axi_araddr == `ADDR_IRQ_STATUS;
    wire rd_ctrl = s_axi_araddr == 12'(`ADDR_MASK_RW_CTRL);
    wire rd_cmp_a = s_axi_araddr == `ADDR_CMP_A;
    wire rd_cmp_b = s_axi_araddr == `ADDR_CMP_B;
    wire rd_mode = s_axi_araddr == `ADDR_MODE;
    wire rd_mask = s_axi_araddr == `ADDR_IRQ_MASK;
    wire rd_state = s_axi_araddr == `ADDR_MATCH_STATE;
    wire rd_known = rd_status | rd_ctrl | rd_cmp_a | rd_cmp_b | rd_mode | rd_mask | rd_state;
    wire [31:0] rd_mux = rd_ctrl ? {24'h000000, ctrl_r}
                       : rd_cmp_a ? {10'h000, cmp_a_r}
                       : rd_cmp_b ? {10'h000, cmp_b_r}
                       : rd_mode ? {30'h00000000, mode_r}
                       : rd_mask ? {30'h00000000, irq_mask_r}
                       : rd_status ? {30'h00000000, irq_status_r}
                       : rd_state ? {30'h00000000, match_b_r, match_a_r}
                       : 32'h00000000;

    // read data register; unmapped answers slverr with zero
    // rvalid falls on the edge that sees rready; a new
    // request cannot be taken in that same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // =====================================================
    // software registers
    // byte registers take lane 0 only; comparator words
    // merge lanes 0 to 2 so software may update one byte
    // of a comparator without a read-modify-write.
    // status and match state are read only: writes to
    // them answer okay and change nothing.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `RST_CTRL;
            cmp_a_r <= `RST_CMP;
            cmp_b_r <= `RST_CMP;
            mode_r <= `RST_MODE;
            irq_mask_r <= `RST_IRQ;
        end else if (do_write) begin
            if (wr_ctrl && ws[0]) ctrl_r <= wd[7:0];
            if (wr_cmp_a) cmp_a_r <= cmp_a_nxt;
            if (wr_cmp_b) cmp_b_r <= cmp_b_nxt;
            if (wr_mode && ws[0]) mode_r <= wd[1:0];
            if (wr_mask && ws[0]) irq_mask_r <= wd[1:0];
        end
    end

    // =====================================================
    // match outputs and sticky events; a new hit beats the read clear
    // the clear is taken from the read handshake, not from
    // rvalid, so the read data shows the bits that were
    // cleared. a hit in the clearing cycle survives, so
    // an event is never lost between read and clear.
    // irq uses the next status so it changes together with it.
    wire [1:0] status_clr = (ar_fire & rd_status) ? 2'h3 : 2'h0;
    wire [1:0] status_nxt = (irq_status_r & ~status_clr) | {hit_b, hit_a};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_a_r <= 1'b0;
            match_b_r <= 1'b0;
            irq_status_r <= `RST_IRQ;
            irq_r <= 1'b0;
        end else begin
            match_a_r <= hit_a;
            match_b_r <= hit_b;
            irq_status_r <= status_nxt;
            irq_r <= |(status_nxt & irq_mask_r);
        end
    end

    // =====================================================
    // outputs
    // bus readiness is decoded from state flops; data,
    // responses, matches and irq come from registers.
    assign s_axi_awready = ~aw_got_r & (wr_state_r != WS_RESP);
    assign s_axi_wready = ~w_got_r & (wr_state_r != WS_RESP);
    assign s_axi_bvalid = wr_state_r == WS_RESP;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign match_a = match_a_r;
    assign match_b = match_b_r;
    assign irq = irq_r;
endmodule : breakpoint_mask_rw_qualifier

// File: bkpt_consts.svh
`ifndef BKPT_CONSTS_SVH
`define BKPT_CONSTS_SVH
// =====================================================
// register byte addresses (printed offsets are not all multiples of four)
`define IDX_MASK_RW_CTRL 8'h29
`define ADDR_MASK_RW_CTRL (`IDX_MASK_RW_CTRL * 4)
`define ADDR_CMP_A 12'h000
`define ADDR_CMP_B 12'h004
`define ADDR_MODE 12'h008
`define ADDR_IRQ_STATUS 12'h00C
`define ADDR_IRQ_MASK 12'h010
`define ADDR_MATCH_STATE 12'h014
// =====================================================
// control field positions
`define F_A_MASK_H 7
`define F_A_MASK_L 6
`define F_B_MASK_H 5
`define F_B_MASK_L 4
`define F_A_DIR_EN 3
`define F_A_DIR_VAL 2
`define F_B_DIR_EN 1
`define F_B_DIR_VAL 0
// =====================================================
// mode register bits
`define F_MODE_BKPT 0
`define F_MODE_FULL 1
// =====================================================
// reset values
`define RST_CTRL 8'h00
`define RST_CMP 22'h000000
`define RST_MODE 2'h0
`define RST_IRQ 2'h0
`endif

// File: bkpt_pkg.sv
package bkpt_pkg;
    // axi response codes
    typedef enum logic [1:0] {
        RESP_OKAY = 2'h0,
        RESP_SLVERR = 2'h2
    } axi_resp_t;
    // write-side handshake states
    typedef enum logic [2:0] {
        WS_IDLE = 3'b001,
        WS_COLLECT = 3'b010,
        WS_RESP = 3'b100
    } wr_state_t;
endpackage : bkpt_pkg

// File: bkpt_cpu_model.sv
`timescale 1ns/1ps
// =========================================
// cpu bus stand-in, aimed at comparator values
module bkpt_cpu_model (
    input wire logic aclk,
    input wire logic en,
    input wire logic [21:0] hint_a,
    input wire logic [21:0] hint_b,
    output logic bus_valid,
    output logic [15:0] cpu_addr,
    output logic [5:0] program_page_select,
    output logic program_page_access,
    output logic [15:0] cpu_data,
    output logic cpu_read
);
    logic [21:0] h; // comparator aimed at this cycle
    logic [31:0] r; // fresh random bits
    initial begin
        {bus_valid, cpu_addr, program_page_select, program_page_access, cpu_data, cpu_read} = 41'h0;
    end
    // one cycle per clock; idle address, page and data lines flip so stale values never pass for live ones
    always @(posedge aclk) begin
        r = $urandom;
        h = r[7] ? hint_a : hint_b;
        if (en) begin
            bus_valid <= 1'h1;
            cpu_addr <= r[0] ? {h[15:8], r[1] ? h[7:0] : r[15:8]} : r[31:16];
            program_page_select <= r[2] ? h[21:16] : r[13:8];
            program_page_access <= r[3];
            cpu_data <= {r[4] ? hint_b[15:8] : r[23:16], r[5] ? hint_b[7:0] : r[31:24]};
            cpu_read <= r[6];
        end else begin
            bus_valid <= 1'h0;
            cpu_addr <= ~cpu_addr;
            program_page_select <= ~program_page_select;
            cpu_data <= ~cpu_data;
        end
    end
endmodule : bkpt_cpu_model

// File: breakpoint_mask_rw_qualifier_chk.sv
`timescale 1ns/1ps
// =========================================
// port watcher
module breakpoint_mask_rw_qualifier_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic bus_valid,
    input wire logic program_page_access,
    input wire logic cpu_read,
    input wire logic match_a,
    input wire logic match_b
);
    logic [7:0] ctl_r; // shadow of control byte
    logic [1:0] mode_r; // shadow of mode bits
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; // both taken at once
    // shadows assume address and data move together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_r <= 8'h00;
            mode_r <= 2'h0;
        end else if (wr_go && s_axi_awaddr == 12'h0A4) begin
            ctl_r <= s_axi_wdata[7:0];
        end else if (wr_go && s_axi_awaddr == 12'h008) begin
            mode_r <= s_axi_wdata[1:0];
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bus_gate_a: assert property (match_a |-> $past(bus_valid)) else $error("match a idle");
    a_bus_gate_b: assert property (match_b |-> $past(bus_valid)) else $error("match b idle");
    a_dir_qual_a: assert property (match_a && ctl_r[3] |-> $past(cpu_read) == ctl_r[2]) else $error("a dir");
    a_dir_qual_b: assert property (match_b && ctl_r[1] && !mode_r[1] |-> $past(cpu_read) == ctl_r[0]) else $error("b dir");
    a_page_only_a: assert property (match_a && mode_r[0] && ctl_r[7:6] == 2'h3 |-> $past(program_page_access)) else $error("a page");
    a_page_only_b: assert property (match_b && mode_r == 2'h1 && ctl_r[5:4] == 2'h3 |-> $past(program_page_access)) else $error("b page");
    a_b_after_both: assert property (wr_go |=> s_axi_bvalid) else $error("late write response");
    a_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read data");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    c_hit_a: cover property (match_a);
    c_hit_b: cover property (match_b);
    c_write: cover property (s_axi_bvalid);
endmodule : breakpoint_mask_rw_qualifier_chk
bind breakpoint_mask_rw_qualifier breakpoint_mask_rw_qualifier_chk u_breakpoint_mask_rw_qualifier_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .bus_valid(bus_valid),
    .program_page_access(program_page_access), .cpu_read(cpu_read), .match_a(match_a), .match_b(match_b));

// File: tb_breakpoint_mask_rw_qualifier.sv
`timescale 1ns/1ps
`include "bkpt_consts.svh"
// =========================================
// random bus traffic against a shadow prediction
module tb_breakpoint_mask_rw_qualifier;
    import bkpt_pkg::*;
    localparam logic [11:0] ctl_addr = 12'(`ADDR_MASK_RW_CTRL);
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, en = 1'h0, run = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, bv, pa, rd, match_a, match_b, irq;
    logic [31:0] rdata;
    axi_resp_t bresp, rresp;
    logic [15:0] addr, dat;
    logic [5:0] pg;
    logic [21:0] ca = 22'h0, cb = 22'h0; // comparator shadows
    logic [7:0] ctl = 8'h00; // control shadow
    logic [1:0] md = 2'h0, sticky = 2'h0;
    logic ea = 1'h0, eb = 1'h0; // predicted match for this cycle
    int error_cnt = 0, check_count = 0, cyc = 0;
    always #12.5 aclk = ~aclk;
    // response ready is held high, which the bus allows
    breakpoint_mask_rw_qualifier u_breakpoint_mask_rw_qualifier (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
        .bus_valid(bv), .cpu_addr(addr), .program_page_select(pg), .program_page_access(pa), .cpu_data(dat),
        .cpu_read(rd), .match_a(match_a), .match_b(match_b), .irq(irq));
    bkpt_cpu_model u_bkpt_cpu_model (.aclk(aclk), .en(en), .hint_a(ca), .hint_b(cb), .bus_valid(bv), .cpu_addr(addr),
        .program_page_select(pg), .program_page_access(pa), .cpu_data(dat), .cpu_read(rd));
    // address compare under one mask code
    function automatic logic hit(input logic [21:0] c, input logic [1:0] m);
        logic x, h;
        x = !pa || c[21:16] == pg;
        h = pa ? c[13:8] == addr[13:8] : c[15:8] == addr[15:8];
        if (m == 2'h3) return pa && x;
        if (m == 2'h1) return x && h;
        return x && h && c[7:0] == addr[7:0];
    endfunction : hit
    // debug mode forces a full address compare
    function automatic logic exp_a();
        return bv && hit(ca, md[0] ? ctl[7:6] : 2'h0) && (!ctl[3] || rd == ctl[2]);
    endfunction : exp_a
    function automatic logic exp_b();
        if (md[1]) return bv && (ctl[4] || cb[7:0] == dat[7:0]) && (ctl[5] || cb[15:8] == dat[15:8]);
        return bv && hit(cb, md[0] ? ctl[5:4] : 2'h0) && (!ctl[1] || rd == ctl[0]);
    endfunction : exp_b
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // write: both channels offered, each dropped once taken
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'h0;
        w = 1'h0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw || awready;
            w = w || wready;
            awvalid <= !aw;
            wvalid <= !w;
        end
        do @(posedge aclk); while (!bvalid);
        chk(bresp, RESP_OKAY);
    endtask : axw
    task automatic axr(input logic [11:0] a, output logic [31:0] d, output axi_resp_t s);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        s = rresp;
    endtask : axr
    // outputs settle by the falling edge; compare, then predict the next cycle
    always @(negedge aclk) begin
        if (run) begin
            chk(match_a, ea);
            chk(match_b, eb);
            sticky = sticky | {eb, ea};
            ea = exp_a();
            eb = exp_b();
        end
    end
    // hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        logic [31:0] d;
        axi_resp_t s;
        void'($urandom(13));
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        run = 1'h1;
        axr(ctl_addr, d, s);
        chk(d, `RST_CTRL);
        axr(12'h100, d, s);
        chk(d, 32'h0);
        chk(s, RESP_SLVERR);
        axw(`ADDR_IRQ_MASK, 32'h1); // only comparator A may interrupt
        for (int m = 0; m < 4; m++) begin
            md = m[1:0];
            axw(`ADDR_MODE, {30'h0, md});
            for (int i = 0; i < 16; i++) begin
                ca = 22'($urandom);
                cb = 22'($urandom);
                ctl = {i[3:0], 4'($urandom)};
                axw(`ADDR_CMP_A, {10'h0, ca});
                axw(`ADDR_CMP_B, {10'h0, cb});
                axw(ctl_addr, {24'h0, ctl});
                axr(ctl_addr, d, s);
                chk(d, {24'h0, ctl});
                en <= 1'h1;
                repeat (40) @(posedge aclk);
                en <= 1'h0;
                repeat (4) @(posedge aclk);
                chk(irq, sticky[0]);
                axr(`ADDR_IRQ_STATUS, d, s);
                chk(d, {30'h0, sticky});
                sticky = 2'h0;
                $display("test mode %0d mask %0h done", m, i);
            end
        end
        close_out();
    end
endmodule : tb_breakpoint_mask_rw_qualifier
